// ===== rtl/io_and_sram_memory_port.sv
// memory-mapped I/O and static RAM port of the external memory controller
`timescale 1ns/1ns
`include "memport_consts.svh"
module io_and_sram_memory_port
  import memport_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // internal request
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqFetch,
  input wire logic [1:0] reqSize,
  input wire logic [31:0] reqWdata,
  input wire logic [7:0] reqCheckBits,
  // internal answer
  output logic reqReady,
  output logic respValid,
  output logic respTrap,
  output logic [7:0] respTrapCode,
  output logic [31:0] respRdata,
  output logic [7:0] respCheckBits,
  // configuration
  input wire logic ioEnable,
  input wire logic ioWide,
  input wire logic [3:0] ioWait,
  input wire logic ioReadyGate,
  input wire logic asyncReady,
  input wire logic sramEnable,
  input wire logic sramWide,
  input wire logic [3:0] bankSize,
  input wire logic [1:0] sramReadWait,
  input wire logic [1:0] sramWriteWait,
  input wire logic sramRmw,
  input wire logic sramReadyGate,
  input wire logic ramEccEnable,
  input wire logic sdramEnable,
  // external bus
  output logic [27:0] addrOut,
  output logic [31:0] dataOut,
  output logic dataOe,
  input wire logic [31:0] dataIn,
  output logic [7:0] checkBitsOut,
  output logic checkBitsOe,
  input wire logic [7:0] checkBitsIn,
  output logic ioAreaSelectN,
  output logic ioSelectDelayedN,
  output logic outputEnableN,
  output logic readStrobe,
  output logic writeN,
  output logic [4:0] staticBankSelectN,
  output logic [4:0] staticBankOutputEnableN,
  output logic [3:0] staticLaneWriteN,
  input wire logic busReadyN
);
  ctrl_t r;
  ctrl_t next_r;
  logic waitZero;
  logic waitLoad;
  logic waitDec;
  logic [3:0] waitVal;
  logic ready;

  function automatic logic [2:0] first_beat(input logic [4:0] m, input logic [2:0] lo);
    logic [2:0] f;
    f = `NO_BEAT;
    for (int i = 4; i >= 0; i--) begin
      if (m[i] && 3'(i) >= lo) begin
        f = 3'(i);
      end
    end
    return f;
  endfunction : first_beat

  wait_counter #(.W(4)) u_wait (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .load(waitLoad),
    .value(waitVal),
    .dec(waitDec),
    .zero(waitZero)
  );

  ready_sampler u_ready (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .busReadyN(busReadyN),
    .asyncSel(asyncReady),
    .ready(ready)
  );

  // request decode
  logic isIoReq;
  logic isRamReq;
  logic sdramHit;
  logic bank4Hit;
  logic bankLowHit;
  logic [28:0] bankIdx;
  logic [3:0] byteMask;
  logic rmwNeed;
  logic beatRd;
  logic gate;
  logic active;
  logic rdPhase;
  logic [7:0] din8;
  int sh;

  always_comb begin
    isIoReq = (reqAddr[31:29] == `IO_TOP);
    isRamReq = (reqAddr[31:30] == `RAM_TOP);
    bankIdx = reqAddr[28:0] >> (`BANK_SHIFT_MIN + {1'b0, bankSize});
    sdramHit = sdramEnable && reqAddr[29];
    bank4Hit = isRamReq && reqAddr[29:28] == `BANK4_NIBBLE && !sdramEnable;
    // bank 4 before banks 2, 3
    bankLowHit = isRamReq && !reqAddr[29] && bankIdx < `BANK_COUNT_LOW;
    case (reqSize)
      `SIZE_BYTE: byteMask = 4'h1 << reqAddr[1:0];
      `SIZE_HALF: byteMask = reqAddr[1] ? 4'hc : 4'h3;
      default: byteMask = 4'hf;
    endcase
    rmwNeed = reqWrite && reqSize != `SIZE_WORD && (ramEccEnable || sramRmw);
  end

  always_comb begin
    next_r = r;
    waitLoad = 1'b0;
    waitDec = 1'b0;
    beatRd = !r.isWrite || r.rmwRead;
    // shared I/O wait, separate SRAM waits
    waitVal = r.isIo ? ioWait : {2'h0, beatRd ? sramReadWait : sramWriteWait};
    gate = r.isIo ? ioReadyGate : (sramReadyGate && r.bank == `BANK4);
    sh = 8 * (3 - int'(r.beat[1:0]));
    din8 = dataIn[31:24];
    if (ce) begin
      next_r.respValid = 1'b0;
      case (r.st)
        ST_IDLE: begin
          if (reqValid) begin
            next_r.addr = reqAddr;
            next_r.wdata = reqWdata;
            next_r.cbits = reqCheckBits;
            next_r.isWrite = reqWrite;
            next_r.isIo = isIoReq;
            next_r.lane = byteMask;
            next_r.bank = bank4Hit ? `BANK4 : {1'b0, bankIdx[1:0]};
            next_r.respTrap = 1'b0;
            next_r.trapCode = 8'h00;
            next_r.rmwRead = 1'b0;
            if (isIoReq) begin
              next_r.rcb = 8'h00;
              // narrow I/O uses the request size as issued, wide I/O one full-word beat
              next_r.wide = ioWide;
              next_r.beatMask = ioWide ? 5'h01 : {1'b0, byteMask};
            end else begin
              next_r.wide = sramWide;
              next_r.rmwRead = rmwNeed;
              if (sramWide) begin
                next_r.beatMask = 5'h01;
              end else if (!reqWrite || rmwNeed) begin
                next_r.beatMask = {ramEccEnable, 4'hf};
              end else begin
                next_r.beatMask = {ramEccEnable, byteMask};
              end
            end
            if ((isIoReq && !ioEnable) || (!isIoReq && !(sramEnable && !sdramHit && (bank4Hit || bankLowHit)))) begin
              next_r.respValid = 1'b1;
              next_r.respTrap = 1'b1;
              next_r.trapCode = reqWrite ? `TRAP_STORE : (reqFetch ? `TRAP_FETCH : `TRAP_LOAD);
            end else begin
              next_r.beat = first_beat(next_r.beatMask, 3'h0);
              // SRAM read starts in data cycle
              next_r.st = (isIoReq || reqWrite) ? ST_LEAD : ST_DATA1;
            end
          end
        end
        ST_LEAD: begin
          if (beatRd) begin
            next_r.st = ST_DATA1;
          end else begin
            next_r.st = ST_WRITE;
            waitLoad = 1'b1;
          end
        end
        ST_DATA1: begin
          next_r.st = ST_DATA2;
          waitLoad = 1'b1;
        end
        ST_DATA2: begin
          if (!waitZero) begin
            waitDec = 1'b1;
          end else if (!(gate && !ready)) begin
            if (r.wide) begin
              for (int i = 0; i < 4; i++) begin
                if (!r.rmwRead) begin
                  next_r.rdata[8*(3-i) +: 8] = dataIn[8*(3-i) +: 8];
                end else if (!r.lane[i]) begin
                  next_r.wdata[8*(3-i) +: 8] = dataIn[8*(3-i) +: 8];
                end
              end
              next_r.rcb = r.isIo ? 8'h00 : checkBitsIn;
            end else if (r.beat == `CHECK_BEAT) begin
              next_r.rcb = din8;
            end else if (!r.rmwRead) begin
              next_r.rdata[sh +: 8] = din8;
            end else if (!r.lane[r.beat[1:0]]) begin
              next_r.wdata[sh +: 8] = din8;
            end
            next_r.st = r.isIo ? ST_LEADOUT : ST_NEXT;
          end
        end
        ST_WRITE: begin
          if (!waitZero) begin
            waitDec = 1'b1;
          end else if (!(gate && !ready)) begin
            next_r.st = ST_LEADOUT;
          end
        end
        ST_LEADOUT: begin
          next_r.st = ST_NEXT;
        end
        ST_NEXT: begin
          next_r.beat = first_beat(r.beatMask, r.beat + 3'h1);
          if (next_r.beat != `NO_BEAT) begin
            next_r.st = (beatRd && !r.isIo) ? ST_DATA1 : ST_LEAD;
          end else if (r.rmwRead) begin
            next_r.rmwRead = 1'b0;
            next_r.lane = 4'hf;
            next_r.beat = first_beat(r.beatMask, 3'h0);
            next_r.st = ST_LEAD;
          end else begin
            next_r.respValid = 1'b1;
            next_r.st = ST_IDLE;
          end
        end
        default: begin
          next_r.st = ST_IDLE;
        end
      endcase
    end
    // pin levels for the coming cycle
    active = next_r.st inside {ST_LEAD, ST_DATA1, ST_DATA2, ST_WRITE, ST_LEADOUT};
    rdPhase = next_r.st inside {ST_DATA1, ST_DATA2};
    next_r.reqReady = (next_r.st == ST_IDLE);
    next_r.iosN = !(active && next_r.isIo);
    next_r.ioselN = !(next_r.isIo && next_r.st inside {ST_DATA1, ST_DATA2, ST_WRITE});
    next_r.oeN = !rdPhase;
    next_r.readStrobe = rdPhase;
    next_r.writeN = (next_r.st != ST_WRITE);
    next_r.selN = `SEL_IDLE;
    next_r.bankOeN = `SEL_IDLE;
    next_r.laneWrN = `LANE_IDLE;
    if (active && !next_r.isIo) begin
      next_r.selN[next_r.bank] = 1'b0;
      if (rdPhase) begin
        next_r.bankOeN[next_r.bank] = 1'b0;
      end
      if (next_r.st == ST_WRITE) begin
        next_r.laneWrN = next_r.wide ? ~{next_r.lane[0], next_r.lane[1], next_r.lane[2], next_r.lane[3]} : 4'h7;
      end
    end
    if (next_r.wide || next_r.isIo || next_r.beat == `CHECK_BEAT) begin
      next_r.addrOut = next_r.addr[27:0];
    end else begin
      next_r.addrOut = {next_r.addr[27:2], next_r.beat[1:0]};
    end
    next_r.dataOe = active && next_r.isWrite && !next_r.rmwRead && !rdPhase;
    if (next_r.wide) begin
      next_r.dataOut = next_r.wdata;
    end else if (next_r.beat == `CHECK_BEAT) begin
      next_r.dataOut = {next_r.cbits, 24'h000000};
    end else begin
      next_r.dataOut = {next_r.wdata[8*(3-int'(next_r.beat[1:0])) +: 8], 24'h000000};
    end
    // checkbits only for wide SRAM writes
    next_r.checkOe = next_r.dataOe && next_r.wide && !next_r.isIo;
    next_r.checkOut = next_r.checkOe ? next_r.cbits : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.reqReady <= 1'b1;
      r.iosN <= 1'b1;
      r.ioselN <= 1'b1;
      r.oeN <= 1'b1;
      r.writeN <= 1'b1;
      r.selN <= `SEL_IDLE;
      r.bankOeN <= `SEL_IDLE;
      r.laneWrN <= `LANE_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign reqReady = r.reqReady;
  assign respValid = r.respValid;
  assign respTrap = r.respTrap;
  assign respTrapCode = r.trapCode;
  assign respRdata = r.rdata;
  assign respCheckBits = r.rcb;
  assign addrOut = r.addrOut;
  assign dataOut = r.dataOut;
  assign dataOe = r.dataOe;
  assign checkBitsOut = r.checkOut;
  assign checkBitsOe = r.checkOe;
  assign ioAreaSelectN = r.iosN;
  assign ioSelectDelayedN = r.ioselN;
  assign outputEnableN = r.oeN;
  assign readStrobe = r.readStrobe;
  assign writeN = r.writeN;
  assign staticBankSelectN = r.selN;
  assign staticBankOutputEnableN = r.bankOeN;
  assign staticLaneWriteN = r.laneWrN;

  property p_io_window;
    @(posedge clk) disable iff (srst) !ioAreaSelectN |-> r.addr[31:29] == `IO_TOP;
  endproperty
  a_io_window: assert property (p_io_window) else $error("io select outside io window");
  property p_io_alias;
    @(posedge clk) disable iff (srst) !ioAreaSelectN |-> addrOut == r.addr[27:0];
  endproperty
  a_io_alias: assert property (p_io_alias) else $error("io address not 28-bit alias");
  property p_io_nocheck;
    @(posedge clk) disable iff (srst) !ioAreaSelectN |-> !checkBitsOe && respCheckBits == 8'h00;
  endproperty
  a_io_nocheck: assert property (p_io_nocheck) else $error("checkbits on io access");
  property p_io_disabled;
    @(posedge clk) disable iff (srst || !ce)
      reqReady && reqValid && reqAddr[31:29] == `IO_TOP && !ioEnable
      |=> respValid && respTrap && ioAreaSelectN
          && respTrapCode == ($past(reqWrite) ? `TRAP_STORE : ($past(reqFetch) ? `TRAP_FETCH : `TRAP_LOAD));
  endproperty
  a_io_disabled: assert property (p_io_disabled) else $error("disabled io access not trapped");
  property p_io_delay;
    @(posedge clk) disable iff (srst || !ce) $fell(ioAreaSelectN) |-> ioSelectDelayedN ##1 !ioSelectDelayedN;
  endproperty
  a_io_delay: assert property (p_io_delay) else $error("io delayed select not one clock late");
  property p_write_leadin;
    @(posedge clk) disable iff (srst) $fell(writeN) |-> $past(!ioAreaSelectN || staticBankSelectN != `SEL_IDLE);
  endproperty
  a_write_leadin: assert property (p_write_leadin) else $error("write strobe without lead-in");
  property p_bank_overlap;
    @(posedge clk) disable iff (srst) bankSize == 4'hf |-> staticBankSelectN[3:2] == 2'h3;
  endproperty
  a_bank_overlap: assert property (p_bank_overlap) else $error("bank 2 or 3 selected at 256 MB");
  property p_bank4_region;
    @(posedge clk) disable iff (srst) !staticBankSelectN[4] |-> r.addr[31:28] == 4'h6 && !sdramEnable;
  endproperty
  a_bank4_region: assert property (p_bank4_region) else $error("bank 4 outside its region");
  property p_sdram_prio;
    @(posedge clk) disable iff (srst) sdramEnable && r.addr[31:29] == 3'h3 |-> staticBankSelectN == `SEL_IDLE;
  endproperty
  a_sdram_prio: assert property (p_sdram_prio) else $error("sram selected in sdram area");
  property p_oe_in_select;
    @(posedge clk) disable iff (srst) (~staticBankOutputEnableN & staticBankSelectN) == 5'h00;
  endproperty
  a_oe_in_select: assert property (p_oe_in_select) else $error("bank output enable without select");
  property p_sram_two_cycles;
    @(posedge clk) disable iff (srst || !ce)
      $fell(&staticBankOutputEnableN) && sramReadWait == 2'h0 && !(sramReadyGate && !staticBankSelectN[4])
      |-> !(&staticBankOutputEnableN) ##1 !(&staticBankOutputEnableN) ##1 (&staticBankOutputEnableN);
  endproperty
  a_sram_two_cycles: assert property (p_sram_two_cycles) else $error("zero-wait sram read not two cycles");
endmodule : io_and_sram_memory_port

// ===== rtl/memport_consts.svh
// address decode, trap codes and beat constants for the memory port
`ifndef MEMPORT_CONSTS_SVH
`define MEMPORT_CONSTS_SVH
`define IO_TOP 3'h1
`define RAM_TOP 2'h1
`define BANK4_NIBBLE 2'h2
`define BANK_SHIFT_MIN 5'h0d
`define BANK_COUNT_LOW 29'h00000004
`define TRAP_FETCH 8'h01
`define TRAP_LOAD 8'h09
`define TRAP_STORE 8'h2b
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define CHECK_BEAT 3'h4
`define NO_BEAT 3'h7
`define BANK4 3'h4
`define SEL_IDLE 5'h1f
`define LANE_IDLE 4'hf
`endif

// ===== rtl/memport_pkg.sv
// types shared by the memory port modules
package memport_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_DATA1, ST_DATA2, ST_WRITE, ST_LEADOUT, ST_NEXT} state_t;
  typedef struct packed {
    state_t st;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [7:0] cbits;
    logic [7:0] rcb;
    logic isIo;
    logic isWrite;
    logic wide;
    logic rmwRead;
    logic [2:0] bank;
    logic [3:0] lane;
    logic [4:0] beatMask;
    logic [2:0] beat;
    logic reqReady;
    logic respValid;
    logic respTrap;
    logic [7:0] trapCode;
    logic [27:0] addrOut;
    logic [31:0] dataOut;
    logic dataOe;
    logic [7:0] checkOut;
    logic checkOe;
    logic iosN;
    logic ioselN;
    logic oeN;
    logic readStrobe;
    logic writeN;
    logic [4:0] selN;
    logic [4:0] bankOeN;
    logic [3:0] laneWrN;
  } ctrl_t;
  typedef struct packed {
    logic s1;
    logic s2;
    logic sy;
  } sampler_t;
endpackage : memport_pkg

// ===== rtl/wait_counter.sv
// wait-state down counter
`timescale 1ns/1ns
module wait_counter #(
  parameter int W = 4
) (
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // load and count
  input wire logic load,
  input wire logic [W-1:0] value,
  input wire logic dec,
  output logic zero
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } count_t;
  count_t r;
  count_t next_r;
  always_comb begin
    next_r = r;
    if (ce && load) begin
      next_r.cnt = value;
    end else if (ce && dec && r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign zero = (r.cnt == '0);
endmodule : wait_counter

// ===== rtl/ready_sampler.sv
// bus-ready sampling, one stage or two-stage synchroniser
`timescale 1ns/1ns
module ready_sampler
  import memport_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // ready pin
  input wire logic busReadyN,
  input wire logic asyncSel,
  output logic ready
);
  sampler_t r;
  sampler_t next_r;
  always_comb begin
    next_r = r;
    if (ce) begin
      next_r.s1 = busReadyN;
      next_r.s2 = r.s1;
      next_r.sy = busReadyN;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end
  assign ready = asyncSel ? !r.s2 : !r.sy;
endmodule : ready_sampler

// ===== tb/mem_partner.sv
// behavioural static RAM and I/O device on the external bus
`timescale 1ns/1ns
module mem_partner (
  // bench control
  input wire logic clk,
  input wire logic narrow,
  input wire logic [3:0] readyLag,
  // bus pins
  input wire logic [27:0] addrOut,
  input wire logic [31:0] dataOut,
  input wire logic [7:0] checkBitsOut,
  input wire logic ioAreaSelectN,
  input wire logic outputEnableN,
  input wire logic writeN,
  input wire logic [4:0] staticBankSelectN,
  input wire logic [3:0] staticLaneWriteN,
  output logic [31:0] dataIn,
  output logic [7:0] checkBitsIn,
  output logic busReadyN
);
  logic [7:0] mem [256];
  logic [7:0] cb [64];
  logic [3:0] held = 4'h0;
  logic [39:0] last = 40'h0;
  logic [7:0] a;
  logic [7:0] w;
  logic sel;
  logic drive;
  assign a = addrOut[7:0];
  assign w = {a[7:2], 2'h0};
  assign sel = !ioAreaSelectN || staticBankSelectN != 5'h1f;
  assign drive = sel && !outputEnableN;
  // released lines show the inverse of the last value
  always_comb begin
    {dataIn, checkBitsIn} = ~last;
    if (drive && narrow) dataIn[31:24] = mem[a];
    if (drive && !narrow) dataIn = {mem[w], mem[w + 8'h1], mem[w + 8'h2], mem[w + 8'h3]};
    if (drive) checkBitsIn = cb[a[7:2]];
  end
  // ready held off for readyLag selected cycles, pulled up when idle
  assign busReadyN = !(sel && held >= readyLag);
  initial begin
    for (int i = 0; i < 64; i++) begin
      cb[i] = 8'h5a;
    end
  end
  always @(posedge clk) begin
    last <= {dataIn, checkBitsIn};
    held <= sel ? held + {3'h0, held != 4'hf} : 4'h0;
    if (!writeN && narrow) mem[a] <= dataOut[31:24];
    for (int i = 0; i < 4; i++) begin
      if (!writeN && !narrow && (!ioAreaSelectN || !staticLaneWriteN[i])) mem[w + 8'(3 - i)] <= dataOut[8*i +: 8];
    end
    if (!writeN && !narrow && ioAreaSelectN) cb[a[7:2]] <= checkBitsOut;
  end
endmodule : mem_partner

// ===== tb/tb_top.sv
// self-checking bench for the I/O and static RAM port
`timescale 1ns/1ns
`include "memport_consts.svh"
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqFetch = 1'b0, narrowBus = 1'b0;
  logic ioEnable = 1'b0, ioWide = 1'b1, ioReadyGate = 1'b0, asyncReady = 1'b0, sramEnable = 1'b1, sramWide = 1'b1;
  logic sramRmw = 1'b0, sramReadyGate = 1'b0, ramEccEnable = 1'b0, sdramEnable = 1'b0;
  logic [3:0] ioWait = 4'h0, bankSize = 4'h0, readyLag = 4'h0;
  logic [1:0] reqSize = 2'h2, sramReadWait = 2'h0, sramWriteWait = 2'h0;
  logic [31:0] reqAddr = 32'h0, reqWdata = 32'h0, lat, iosCyc, wrCyc, beats, rdCyc, err_count = 0, tests_run = 0;
  logic ce = 1'b1, clrCnt = 1'b0;
  logic [31:0] oeBad = 0;
  logic [7:0] reqCheckBits = 8'h0;
  logic reqReady, respValid, respTrap, dataOe, checkBitsOe, ioAreaSelectN, ioSelectDelayedN, outputEnableN;
  logic readStrobe, writeN, busReadyN, selPrev;
  logic [7:0] respTrapCode, respCheckBits, checkBitsOut, checkBitsIn;
  logic [31:0] respRdata, dataOut, dataIn;
  logic [27:0] addrOut;
  logic [4:0] staticBankSelectN, staticBankOutputEnableN, bankSeen;
  logic [3:0] staticLaneWriteN;
  logic [31:0] badr [6] = '{32'h40000000, 32'h40006000, 32'h50000000, 32'h60000000, 32'h58000000, 32'h6c000000};
  logic [3:0] bsz [6] = '{4'h0, 4'h0, 4'hf, 4'hf, 4'he, 4'he};
  logic [4:0] bexp [6] = '{5'h01, 5'h08, 5'h02, 5'h10, 5'h08, 5'h10};

  always #25 clk = ~clk;

  io_and_sram_memory_port i_dut (.clk, .srst, .ce, .reqValid, .reqAddr, .reqWrite, .reqFetch, .reqSize,
    .reqWdata, .reqCheckBits, .reqReady, .respValid, .respTrap, .respTrapCode, .respRdata, .respCheckBits,
    .ioEnable, .ioWide, .ioWait, .ioReadyGate, .asyncReady, .sramEnable, .sramWide, .bankSize, .sramReadWait,
    .sramWriteWait, .sramRmw, .sramReadyGate, .ramEccEnable, .sdramEnable, .addrOut, .dataOut, .dataOe, .dataIn,
    .checkBitsOut, .checkBitsOe, .checkBitsIn, .ioAreaSelectN, .ioSelectDelayedN, .outputEnableN, .readStrobe,
    .writeN, .staticBankSelectN, .staticBankOutputEnableN, .staticLaneWriteN, .busReadyN);

  mem_partner i_mem (.clk, .narrow(narrowBus), .readyLag, .addrOut, .dataOut, .checkBitsOut, .ioAreaSelectN,
    .outputEnableN, .writeN, .staticBankSelectN, .staticLaneWriteN, .dataIn, .checkBitsIn, .busReadyN);

  // pin activity counters
  always @(posedge clk) begin
    selPrev <= !ioAreaSelectN || staticBankSelectN != 5'h1f;
    if (clrCnt) begin
      iosCyc <= 0;
      wrCyc <= 0;
      beats <= 0;
      rdCyc <= 0;
      bankSeen <= 5'h0;
    end else begin
      if (!ioAreaSelectN) iosCyc <= iosCyc + 1;
      if (!writeN) wrCyc <= wrCyc + 1;
      if (readStrobe) rdCyc <= rdCyc + 1;
      if ((!ioAreaSelectN || staticBankSelectN != 5'h1f) && !selPrev) beats <= beats + 1;
      bankSeen <= bankSeen | ~staticBankSelectN;
    end
    if ((~staticBankOutputEnableN & staticBankSelectN) != 5'h0) oeBad <= oeBad + 1;
  end

  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic access(input logic [31:0] addr, input logic wr, input logic [31:0] wd);
    clrCnt = 1'b1;
    reqAddr = addr;
    reqWrite = wr;
    reqWdata = wd;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    clrCnt = 1'b0;
    lat = 1;
    while (respValid !== 1'b1 && lat < 32'd60) begin
      @(negedge clk);
      lat++;
    end
    if (lat >= 32'd60) begin
      err_count++;
      finish_test();
    end
  endtask : access

  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    for (int k = 0; k < 3; k++) begin
      reqFetch = k == 0;
      access(32'h20000000, k == 2, 32'h0);
      check(32'(respTrapCode), k == 0 ? 32'h01 : k == 1 ? 32'h09 : 32'h2b);
      check(iosCyc + {31'h0, respTrap}, 32'h1);
    end
    reqFetch = 1'b0;
    ioEnable = 1'b1;
    for (int w = 0; w < 16; w += 5) begin
      ioWait = 4'(w);
      access(32'h20000010, 1'b1, 32'h12345600 + w);
      check(lat, 32'(5 + w));
      check(wrCyc, 32'(1 + w));
      access(32'h30000010, 1'b0, 32'h0);
      check(lat, 32'(6 + w));
      check(iosCyc, 32'(4 + w));
      check(rdCyc, 32'(2 + w));
      check(respRdata, 32'h12345600 + w);
      check(32'(respCheckBits), 32'h0);
    end
    ioWait = 4'h0;
    ioReadyGate = 1'b1;
    readyLag = 4'h6;
    for (int s = 0; s < 2; s++) begin
      asyncReady = 1'(s);
      access(32'h20000010, 1'b0, 32'h0);
      check(32'(lat > 8 && lat < 30), 32'h1);
    end
    ioReadyGate = 1'b0;
    readyLag = 4'h0;
    ioWide = 1'b0;
    narrowBus = 1'b1;
    reqSize = `SIZE_BYTE;
    access(32'h20000021, 1'b1, 32'h00ab0000);
    check(32'(i_mem.mem[8'h21]), 32'hab);
    check(beats, 32'h1);
    narrowBus = 1'b0;
    reqSize = `SIZE_WORD;
    for (int i = 0; i < 6; i++) begin
      bankSize = bsz[i];
      reqCheckBits = 8'h30 + 8'(i);
      access(badr[i], 1'b1, 32'hc0de0000 + i);
      check(lat, 32'h5);
      check(32'(bankSeen), 32'(bexp[i]));
      access(badr[i], 1'b0, 32'h0);
      check(lat, 32'h4);
      check(rdCyc, 32'h2);
      check(respRdata, 32'hc0de0000 + i);
      check(32'(respCheckBits), 32'h30 + i);
    end
    bankSize = 4'h0;
    sramReadWait = 2'h3;
    sramWriteWait = 2'h2;
    access(32'h40000040, 1'b1, 32'h11223344);
    check(lat, 32'h7);
    check(wrCyc, 32'h3);
    access(32'h40000040, 1'b0, 32'h0);
    check(lat, 32'h7);
    sramReadWait = 2'h0;
    sramWriteWait = 2'h0;
    reqSize = `SIZE_BYTE;
    access(32'h40000042, 1'b1, 32'h0000ee00);
    check(lat, 32'h5);
    ramEccEnable = 1'b1;
    sramRmw = 1'b1;
    access(32'h40000041, 1'b1, 32'h00dd0000);
    check(32'(lat > 5), 32'h1);
    check(wrCyc, 32'h1);
    reqSize = `SIZE_WORD;
    access(32'h40000040, 1'b0, 32'h0);
    check(respRdata, 32'h11ddee44);
    fork
      access(32'h40000040, 1'b0, 32'h0);
      begin
        @(negedge clk);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
      end
    join
    check(lat, 32'h7);
    check(respRdata, 32'h11ddee44);
    ioWide = 1'b1;
    access(32'h20000010, 1'b0, 32'h0);
    check(32'(respCheckBits), 32'h0);
    ramEccEnable = 1'b0;
    sramRmw = 1'b0;
    sramWide = 1'b0;
    narrowBus = 1'b1;
    access(32'h40000080, 1'b1, 32'ha1b2c3d4);
    check(beats, 32'h4);
    check(32'(i_mem.mem[8'h80]), 32'ha1);
    access(32'h40000080, 1'b0, 32'h0);
    check(respRdata, 32'ha1b2c3d4);
    ramEccEnable = 1'b1;
    sramRmw = 1'b1;
    access(32'h40000080, 1'b0, 32'h0);
    check(beats, 32'h5);
    ramEccEnable = 1'b0;
    sramRmw = 1'b0;
    sramWide = 1'b1;
    narrowBus = 1'b0;
    sramReadyGate = 1'b1;
    readyLag = 4'h8;
    access(32'h40000000, 1'b0, 32'h0);
    check(lat, 32'h4);
    access(32'h60000000, 1'b0, 32'h0);
    check(32'(lat > 4), 32'h1);
    sdramEnable = 1'b1;
    access(32'h60000000, 1'b0, 32'h0);
    check(32'(respTrapCode), 32'h09);
    check(32'(bankSeen), 32'h0);
    check(oeBad, 32'h0);
    finish_test();
  end
endmodule : tb_top
